// ---- rtl/tcr_pkg.sv ----
package tcr_pkg;
  // ==========================================
  // strap decode
  // three-level strap seen as two digital comparator outputs
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h67;
  localparam logic [6:0] ADDR_STRAP_LOW = 7'h47;
  // ==========================================
  // role field encodings
  localparam logic [1:0] ROLE_DRP = 2'h0;
  localparam logic [1:0] ROLE_UFP = 2'h1;
  localparam logic [1:0] ROLE_DFP = 2'h2;
  localparam logic [1:0] ROLE_DRP_ALT = 2'h3;
  localparam logic [1:0] ROLE_RESET = 2'h0;
  // ==========================================
  // timing
  localparam int CLK_MHZ = 25;
  localparam int SOFT_RESET_NS = 400;
  localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    TCR_UNATT_SNK,
    TCR_UNATT_SRC,
    TCR_ATT_SNK,
    TCR_ATT_SRC,
    TCR_FORCED
  } tcr_state_t;

  // attach detector result carried as one group
  typedef struct packed {
    logic attach_snk;
    logic attach_src;
    logic detach;
    logic on_line_b;
  } tcr_attach_t;
endpackage : tcr_pkg

// ---- rtl/tcr_port_role.sv ----
`timescale 1ns/1ps
module tcr_port_role
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // pins (asynchronous)
  input wire logic STRAP_HIGH,
  input wire logic STRAP_LOW,
  input wire logic ENABLE_N,
  input wire logic BUS_POWER_SENSE,
  // attach detector, same clock
  input wire tcr_pkg::tcr_attach_t ATTACH,
  // register side, same clock
  input wire logic ROLE_WE,
  input wire logic [1:0] ROLE_WDATA,
  input wire logic SOFT_RESET_SET,
  input wire logic ALERT_SERVICED,
  // status
  output logic I2C_MODE,
  output logic [6:0] TARGET_ADDR,
  output logic [1:0] ROLE_FIELD,
  output logic SOFT_RESET_BIT,
  output logic CABLE_FLIP,
  output logic ATTACHED_SRC,
  output logic VCONN_EN,
  output tcr_pkg::tcr_state_t PORT_STATE,
  // open-drain pins, enable low = driving low; ORIENTATION is a plain output
  output logic CHANGE_ALERT_OUT_O,
  output logic CHANGE_ALERT_OUT_OE_N,
  output logic HOST_ROLE_INDICATOR_O,
  output logic HOST_ROLE_INDICATOR_OE_N,
  output logic ORIENTATION
);
  import tcr_pkg::*;

  // ==========================================
  // pin synchronisers
  logic [3:0] pins_s;
  logic strap_hi, strap_lo, en_n_s, bus_pwr;
  tcr_sync #(.WIDTH(4)) u_sync (
    .clk(CLK),
    .ce(CE),
    .nrst(NRST),
    .d({STRAP_HIGH, STRAP_LOW, ENABLE_N, BUS_POWER_SENSE}),
    .q(pins_s)
  );
  assign {strap_hi, strap_lo, en_n_s, bus_pwr} = pins_s;

  // ==========================================
  // strap capture after reset release
  logic strap_taken;
  logic [1:0] settle;
  logic mode_i2c, addr_hi;
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      settle <= 2'h0;
      strap_taken <= 1'b0;
      mode_i2c <= 1'b0;
      addr_hi <= 1'b0;
    end
    else if (CE && !strap_taken)
    begin
      // wait for the synchroniser to fill before trusting the strap
      settle <= settle + 2'h1;
      if (settle == 2'h2)
      begin
        strap_taken <= 1'b1;
        mode_i2c <= strap_hi | strap_lo;
        addr_hi <= strap_hi;
      end
    end
  end
  assign I2C_MODE = mode_i2c;
  assign TARGET_ADDR = addr_hi ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;

  // ==========================================
  // soft reset sequencer
  logic [7:0] sr_cnt;
  logic sr_busy;
  wire sr_done = sr_busy && (sr_cnt == 8'(SOFT_RESET_CYC - 1));
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      sr_busy <= 1'b0;
      sr_cnt <= 8'h00;
    end
    else if (CE)
    begin
      if (sr_done)
      begin
        sr_busy <= 1'b0;
        sr_cnt <= 8'h00;
      end
      else if (sr_busy)
        sr_cnt <= sr_cnt + 8'h01;
      else if (SOFT_RESET_SET)
        sr_busy <= 1'b1;
    end
  end
  assign SOFT_RESET_BIT = sr_busy;

  // ==========================================
  // role field and exit events
  logic [1:0] role;
  logic en_n_q;
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      role <= ROLE_RESET;
      // same level as the synchroniser after reset, so no false fall
      en_n_q <= 1'b0;
    end
    else if (CE)
    begin
      en_n_q <= en_n_s;
      if (ROLE_WE && mode_i2c)
        role <= ROLE_WDATA;
    end
  end
  assign ROLE_FIELD = role;
  wire en_fall = en_n_q && !en_n_s;
  wire role_exit = (ROLE_WE && mode_i2c) || SOFT_RESET_SET || en_fall || sr_busy;
  wire is_dfp = (role == ROLE_DFP);
  wire is_ufp = (role == ROLE_UFP);
  wire is_drp = (role == ROLE_DRP) || (role == ROLE_DRP_ALT);
  wire held = en_n_s;

  // ==========================================
  // role state machine
  tcr_state_t state, next_state;
  logic flip;
  always_comb
  begin
    next_state = state;
    case (state)
      TCR_FORCED: next_state = is_dfp ? TCR_UNATT_SRC : TCR_UNATT_SNK;
      TCR_UNATT_SNK:
        if (ATTACH.attach_snk && bus_pwr)
          next_state = TCR_ATT_SNK;
        else if (ATTACH.attach_src && is_drp)
          next_state = TCR_ATT_SRC;
      TCR_UNATT_SRC:
        if (ATTACH.attach_src)
          next_state = TCR_ATT_SRC;
      TCR_ATT_SNK:
        if (ATTACH.detach || !bus_pwr)
          next_state = is_dfp ? TCR_UNATT_SRC : TCR_UNATT_SNK;
      TCR_ATT_SRC:
        if (ATTACH.detach)
          next_state = is_dfp ? TCR_UNATT_SRC : TCR_UNATT_SNK;
      default: next_state = TCR_FORCED;
    endcase
    if (is_ufp && next_state == TCR_ATT_SRC)
      next_state = TCR_UNATT_SNK; // sink-only never sources
    if (role_exit || held)
      next_state = TCR_FORCED;
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      state <= TCR_FORCED;
      flip <= 1'b0;
    end
    else if (CE)
    begin
      state <= next_state;
      if (next_state == TCR_ATT_SNK || next_state == TCR_ATT_SRC)
        flip <= !ATTACH.on_line_b;
    end
  end
  assign PORT_STATE = state;
  assign CABLE_FLIP = flip;
  assign ORIENTATION = flip;
  wire att_src = (state == TCR_ATT_SRC);
  assign ATTACHED_SRC = att_src;
  assign VCONN_EN = att_src && !is_ufp;

  // ==========================================
  // host-role indicator
  logic hri_low;
  always_ff @(posedge CLK)
  begin
    if (!NRST)
      hri_low <= 1'b0;
    else if (CE)
      hri_low <= (next_state == TCR_ATT_SRC) && is_drp;
  end
  assign HOST_ROLE_INDICATOR_O = 1'b0;
  assign HOST_ROLE_INDICATOR_OE_N = !hri_low;

  // ==========================================
  // change alert: sticky, set wins over service
  logic alert;
  logic [4:0] snap;
  wire [4:0] visible = {role, flip, sr_busy, (state == TCR_ATT_SNK) || att_src};
  wire changed = (visible != snap);
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      alert <= 1'b0;
      snap <= 5'h00;
    end
    else if (CE)
    begin
      snap <= visible;
      if (changed)
        alert <= 1'b1;
      else if (ALERT_SERVICED)
        alert <= 1'b0;
    end
  end
  assign CHANGE_ALERT_OUT_O = 1'b0;
  assign CHANGE_ALERT_OUT_OE_N = !alert;

  // ==========================================
  // checks
  a_addr_low_strap: assert property (@(posedge CLK) disable iff (!NRST)
    strap_taken && !addr_hi |-> TARGET_ADDR == 7'h47) else $error("bad address");
  a_alert_holds: assert property (@(posedge CLK) disable iff (!NRST)
    CE && alert && !ALERT_SERVICED |=> alert) else $error("alert dropped");
  a_alert_on_change: assert property (@(posedge CLK) disable iff (!NRST)
    CE && changed |=> !CHANGE_ALERT_OUT_OE_N) else $error("no alert");
  a_hri_src_only: assert property (@(posedge CLK) disable iff (!NRST)
    !HOST_ROLE_INDICATOR_OE_N |-> att_src && is_drp) else $error("indicator");
  a_vconn_ufp: assert property (@(posedge CLK) disable iff (!NRST)
    is_ufp |-> !VCONN_EN && !ATTACHED_SRC) else $error("vconn in sink");
  a_exit_role: assert property (@(posedge CLK) disable iff (!NRST)
    CE && SOFT_RESET_SET |=> state == TCR_FORCED) else $error("no exit");
  a_sr_clear: assert property (@(posedge CLK) disable iff (!NRST)
    CE && $rose(sr_busy) |-> ##[1:40] !sr_busy) else $error("sr stuck");
  a_orient_flip: assert property (@(posedge CLK) disable iff (!NRST)
    CE && (next_state == TCR_ATT_SNK || next_state == TCR_ATT_SRC)
    |=> ORIENTATION == !$past(ATTACH.on_line_b) && CABLE_FLIP == ORIENTATION)
    else $error("orient");
  a_role_reset: assert property (@(posedge CLK)
    !NRST |=> ROLE_FIELD == 2'h0) else $error("role reset");
endmodule : tcr_port_role

// ---- rtl/tcr_sync.sv ----
`timescale 1ns/1ps
module tcr_sync #(
  parameter int WIDTH = 1
) (
  // clock and control
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : tcr_sync

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tcr_pkg::*;
  logic clk = 0, nrst = 0, ce = 1, sh = 0, sl = 1, enn = 0, bp = 0, we = 0, sr = 0, sv = 0;
  logic [1:0] wd = 2'h0;
  tcr_attach_t at = '0;
  logic i2c, srb, flip, asrc, vconn, ao, aoe, ho, hoe, ori, al, rl, hm, dm, ve;
  logic [6:0] addr;
  logic [1:0] role;
  tcr_state_t st;
  int fail_count = 0, n_compared = 0;
  always #20 clk = ~clk;
  tcr_port_role tcr_port_role_inst (.CLK(clk), .NRST(nrst), .CE(ce), .STRAP_HIGH(sh),
    .STRAP_LOW(sl), .ENABLE_N(enn), .BUS_POWER_SENSE(bp), .ATTACH(at), .ROLE_WE(we),
    .ROLE_WDATA(wd), .SOFT_RESET_SET(sr), .ALERT_SERVICED(sv), .I2C_MODE(i2c),
    .TARGET_ADDR(addr), .ROLE_FIELD(role), .SOFT_RESET_BIT(srb), .CABLE_FLIP(flip),
    .ATTACHED_SRC(asrc), .VCONN_EN(vconn), .PORT_STATE(st), .CHANGE_ALERT_OUT_O(ao),
    .CHANGE_ALERT_OUT_OE_N(aoe), .HOST_ROLE_INDICATOR_O(ho),
    .HOST_ROLE_INDICATOR_OE_N(hoe), .ORIENTATION(ori));
  tcr_host_model tcr_host_model_inst (.alert_o(ao), .alert_oe_n(aoe), .role_o(ho),
    .role_oe_n(hoe), .bus_power(bp), .alert_line(al), .role_line(rl), .host_mode(hm),
    .device_mode(dm), .vbus_enable(ve));
  task close_out;
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task do_reset;
    nrst = 0;
    step(16);
    nrst = 1;
    step(5);
  endtask : do_reset
  task write_role(input logic [1:0] v);
    wd = v;
    we = 1;
    step(1);
    we = 0;
    step(4);
  endtask : write_role
  // alert must hold until serviced, then let go
  task service;
    chk("alert", 8'h00, {7'h0, al});
    sv = 1;
    step(1);
    sv = 0;
    step(2);
    chk("alert", 8'h01, {7'h0, al});
  endtask : service
  task t_strap;
    chk("i2c", 8'h01, {7'h0, i2c});
    chk("addr", 8'h47, {1'b0, addr});
    chk("role", 8'h00, {6'h0, role});
    chk("state", {5'h0, TCR_UNATT_SNK}, {5'h0, st});
    sh = 1;
    sl = 0;
    do_reset;
    chk("addr", 8'h67, {1'b0, addr});
    chk("i2c", 8'h01, {7'h0, i2c});
    sh = 0;
    do_reset;
    chk("i2c", 8'h00, {7'h0, i2c});
    write_role(2'h2);
    chk("role", 8'h00, {6'h0, role});
    sl = 1;
    do_reset;
  endtask : t_strap
  task t_roles;
    static logic [1:0] codes [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    static tcr_state_t exp [4] = '{TCR_UNATT_SRC, TCR_UNATT_SNK, TCR_UNATT_SNK,
      TCR_UNATT_SNK};
    for (int i = 0; i < 4; i++)
    begin
      write_role(codes[i]);
      chk("role", {6'h0, codes[i]}, {6'h0, role});
      chk("state", {5'h0, exp[i]}, {5'h0, st});
      service;
    end
  endtask : t_roles
  task t_drp_src;
    chk("vbus", 8'h00, {7'h0, ve});
    at.on_line_b = 1;
    at.attach_src = 1;
    step(1);
    at.attach_src = 0;
    step(3);
    chk("asrc", 8'h01, {7'h0, asrc});
    chk("host", 8'h01, {7'h0, hm});
    chk("vconn", 8'h01, {7'h0, vconn});
    chk("flip", 8'h00, {7'h0, flip});
    chk("orient", 8'h00, {7'h0, ori});
    chk("vbus", 8'h01, {7'h0, ve});
    chk("device", 8'h00, {7'h0, dm});
    service;
    bp = 1;
    at.detach = 1;
    step(1);
    at.detach = 0;
    step(3);
    chk("device", 8'h01, {7'h0, dm});
    chk("vbus", 8'h00, {7'h0, ve});
    service;
  endtask : t_drp_src
  task t_ufp_snk;
    write_role(2'h1);
    service;
    at.on_line_b = 0;
    at.attach_snk = 1;
    step(1);
    at.attach_snk = 0;
    step(3);
    chk("state", {5'h0, TCR_ATT_SNK}, {5'h0, st});
    chk("flip", 8'h01, {7'h0, flip});
    chk("orient", 8'h01, {7'h0, ori});
    chk("vconn", 8'h00, {7'h0, vconn});
    chk("indic", 8'h01, {7'h0, rl});
    service;
    enn = 1;
    step(3);
    chk("state", {5'h0, TCR_FORCED}, {5'h0, st});
    enn = 0;
    step(4);
    chk("state", {5'h0, TCR_UNATT_SNK}, {5'h0, st});
  endtask : t_ufp_snk
  task t_soft;
    sr = 1;
    step(1);
    sr = 0;
    chk("srb", 8'h01, {7'h0, srb});
    chk("state", {5'h0, TCR_FORCED}, {5'h0, st});
    // three frozen cycles stretch the soft reset by three
    ce = 0;
    step(3);
    ce = 1;
    chk("srb", 8'h01, {7'h0, srb});
    step(9);
    chk("srb", 8'h01, {7'h0, srb});
    step(1);
    chk("srb", 8'h00, {7'h0, srb});
  endtask : t_soft
  initial
  begin
    do_reset;
    t_strap;
    t_roles;
    t_drp_src;
    t_ufp_snk;
    t_soft;
    close_out;
  end
  // whole run is well under 1000 cycles
  initial
  begin
    #400000;
    fail_count++;
    close_out;
  end
endmodule : tb_top

// ---- testbench/tcr_host_model.sv ----
`timescale 1ns/1ps
// ==========================================
// far side: pull-ups and otg controller
module tcr_host_model (
  // open-drain pins
  input wire logic alert_o,
  input wire logic alert_oe_n,
  input wire logic role_o,
  input wire logic role_oe_n,
  input wire logic bus_power,
  // resolved lines and controller role
  output logic alert_line,
  output logic role_line,
  output logic host_mode,
  output logic device_mode,
  output logic vbus_enable
);
  // released pins read high through the pull-ups
  assign alert_line = alert_oe_n ? 1'b1 : alert_o;
  assign role_line = role_oe_n ? 1'b1 : role_o;
  assign host_mode = !role_line;
  // power only once the indicator shows an attached source
  assign vbus_enable = host_mode;
  assign device_mode = role_line && bus_power;
endmodule : tcr_host_model
